// >>> core/uafc_serial.v
`timescale 1ns/1ps
`default_nettype none
`include "uafc_defs.vh"

module uafc_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   reg [AW:0]      count_r;
   wire            push;
   wire            pop;

   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

module uafc_serial (
   // clock and reset
   input  wire                   SYS_CLK,
   input  wire                   RST_N,
   // serial line
   input  wire                   RXD,
   output reg                    TXD,
   // bit periods in clocks
   input  wire [`UAFC_DIV_W-1:0] RX_BIT_DIV,
   input  wire [`UAFC_DIV_W-1:0] TX_BIT_DIV,
   // configuration
   input  wire                   FRAME_ERROR_SELECT,
   input  wire [7:0]             SLAVE_ADDR_VALUE,
   input  wire [7:0]             SLAVE_ADDR_MASK,
   // serial control register access
   input  wire                   CTRL_WR,
   input  wire [7:0]             CTRL_WDATA,
   output reg  [7:0]             CTRL_RDATA,
   // transmit stream
   input  wire                   TX_VALID,
   output reg                    TX_READY,
   input  wire [7:0]             TX_DATA,
   // receive stream, bit 8 is the ninth bit
   output reg                    RX_VALID,
   input  wire                   RX_READY,
   output reg  [8:0]             RX_DATA
);
   reg        rxd_s1_r;
   reg        rxd_s2_r;
   reg        rxd_prev_r;
   reg        mode_hi_r;
   reg        mode_lo_r;
   reg        mp_en_r;
   reg        rx_en_r;
   reg        tx_b8_r;
   reg        rx_b8_r;
   reg        tx_done_r;
   reg        rx_done_r;
   reg        fe_flag_r;
   reg [2:0]  rx_st_r;
   reg [15:0] rx_cnt_r;
   reg [3:0]  rx_bit_r;
   reg [8:0]  rx_sh_r;
   reg        rx_taken_r;
   reg        pend_v_r;
   reg [8:0]  pend_r;
   reg [10:0] tx_sh_r;
   reg [3:0]  tx_left_r;
   reg [15:0] tx_cnt_r;
   reg        tx_busy_r;

   wire [1:0] mode      = {mode_hi_r, mode_lo_r};
   wire       async     = (mode != `UAFC_MODE_SHIFT);
   wire       nine_bit  = mode_hi_r;
   // mode 0 masks multiproc enable entirely
   wire       recog_on  = mp_en_r & async;
   wire       fe_check  = FRAME_ERROR_SELECT & async;
   wire [7:0] bcast     = SLAVE_ADDR_VALUE | SLAVE_ADDR_MASK;
   wire [3:0] last_bit  = nine_bit ? 4'h8 : 4'h7;
   wire       rx_tick   = (rx_cnt_r == 16'h0000);
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [8:0] fifo_out_data;
   wire       out_take  = fifo_out_valid & (!RX_VALID | RX_READY);

   // decision point and the word it is about
   reg        decide;
   reg [8:0]  word;
   reg        addr_bit;
   reg        given_hit;
   reg        bcast_hit;
   reg        accept;

   always @* begin
      decide    = 1'b0;
      word      = {1'b0, rx_sh_r[7:0]};
      given_hit = 1'b0;
      bcast_hit = 1'b0;
      addr_bit  = 1'b0;
      accept    = 1'b0;
      if (rx_st_r == `UAFC_ST_DATA && rx_tick && rx_bit_r == last_bit
          && !fe_check && !(recog_on && !nine_bit)) begin
         // no stop check needed: done at the last data bit
         decide = 1'b1;
         word   = nine_bit ? {rxd_s2_r, rx_sh_r[8:1]}
                           : {1'b0, rxd_s2_r, rx_sh_r[8:2]};
      end else if (rx_st_r == `UAFC_ST_STOP && rx_tick && !rx_taken_r) begin
         decide = 1'b1;
         word   = nine_bit ? rx_sh_r : {rxd_s2_r, rx_sh_r[8:1]};
      end
      // mode 1: the stop bit takes the ninth bit's place
      addr_bit  = nine_bit ? word[8] : rxd_s2_r;
      given_hit = ((word[7:0] ^ SLAVE_ADDR_VALUE)
                   & SLAVE_ADDR_MASK) == 8'h00;
      bcast_hit = ((word[7:0] & bcast) == bcast);
      if (!recog_on) begin
         accept = 1'b1;
      end else begin
         // a valid stop also required in mode 1
         accept = addr_bit & (given_hit | bcast_hit);
      end
   end

   // line synchroniser
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rxd_s1_r   <= 1'b1;
         rxd_s2_r   <= 1'b1;
         rxd_prev_r <= 1'b1;
      end else begin
         rxd_s1_r   <= RXD;
         rxd_s2_r   <= rxd_s1_r;
         rxd_prev_r <= rxd_s2_r;
      end
   end

   // receiver; a held word stalls the next start until the fifo frees
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rx_st_r    <= `UAFC_ST_IDLE;
         rx_cnt_r   <= 16'h0000;
         rx_bit_r   <= 4'h0;
         rx_sh_r    <= 9'h000;
         rx_taken_r <= 1'b0;
         pend_v_r   <= 1'b0;
         pend_r     <= 9'h000;
      end else begin
         if (pend_v_r && fifo_in_ready) begin
            pend_v_r <= 1'b0;
         end
         if (decide && accept) begin
            pend_v_r <= 1'b1;
            pend_r   <= word;
         end
         rx_cnt_r <= rx_tick ? RX_BIT_DIV - 16'h0001
                             : rx_cnt_r - 16'h0001;
         case (rx_st_r)
            `UAFC_ST_IDLE: begin
               rx_taken_r <= 1'b0;
               if (async && rx_en_r && !pend_v_r
                   && rxd_prev_r && !rxd_s2_r) begin
                  rx_st_r  <= `UAFC_ST_START;
                  rx_cnt_r <= {1'b0, RX_BIT_DIV[15:1]};
               end
            end
            `UAFC_ST_START: begin
               if (rx_tick) begin
                  // a glitch shorter than half a bit is ignored
                  rx_st_r  <= rxd_s2_r ? `UAFC_ST_IDLE : `UAFC_ST_DATA;
                  rx_bit_r <= 4'h0;
               end
            end
            `UAFC_ST_DATA: begin
               if (rx_tick) begin
                  rx_sh_r  <= {rxd_s2_r, rx_sh_r[8:1]};
                  rx_bit_r <= rx_bit_r + 4'h1;
                  if (rx_bit_r == last_bit) begin
                     rx_st_r    <= `UAFC_ST_STOP;
                     rx_taken_r <= decide;
                  end
               end
            end
            `UAFC_ST_STOP: begin
               if (rx_tick) begin
                  rx_st_r <= `UAFC_ST_IDLE;
               end
            end
            default: begin
               rx_st_r <= `UAFC_ST_IDLE;
            end
         endcase
      end
   end

   wire fe_event = (rx_st_r == `UAFC_ST_STOP) && rx_tick
                   && fe_check && !rxd_s2_r;

   // transmitter, independent bit period
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tx_sh_r   <= 11'h7ff;
         tx_left_r <= 4'h0;
         tx_cnt_r  <= 16'h0000;
         tx_busy_r <= 1'b0;
         TXD       <= 1'b1;
         TX_READY  <= 1'b0;
      end else begin
         TX_READY <= async && !tx_busy_r && !(TX_VALID && TX_READY);
         if (TX_VALID && TX_READY) begin
            tx_busy_r <= 1'b1;
            tx_cnt_r  <= TX_BIT_DIV - 16'h0001;
            tx_left_r <= nine_bit ? `UAFC_TX_LEN_9 : `UAFC_TX_LEN_8;
            tx_sh_r   <= nine_bit ? {1'b1, tx_b8_r, TX_DATA, 1'b0}
                                  : {2'b11, TX_DATA, 1'b0};
            TXD       <= 1'b0;
         end else if (tx_busy_r) begin
            if (tx_cnt_r == 16'h0000) begin
               tx_cnt_r  <= TX_BIT_DIV - 16'h0001;
               tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
               TXD       <= tx_sh_r[1];
               tx_left_r <= tx_left_r - 4'h1;
               if (tx_left_r == 4'h1) begin
                  tx_busy_r <= 1'b0;
                  TXD       <= 1'b1;
               end
            end else begin
               tx_cnt_r <= tx_cnt_r - 16'h0001;
            end
         end
      end
   end

   wire tx_stop_start = tx_busy_r && tx_cnt_r == 16'h0000
                        && tx_left_r == 4'h2;

   // control register; hardware sets win over software clears
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         mode_hi_r <= 1'b0;
         mode_lo_r <= 1'b0;
         mp_en_r   <= 1'b0;
         rx_en_r   <= 1'b0;
         tx_b8_r   <= 1'b0;
         rx_b8_r   <= 1'b0;
         tx_done_r <= 1'b0;
         rx_done_r <= 1'b0;
         fe_flag_r <= 1'b0;
      end else begin
         if (CTRL_WR) begin
            if (FRAME_ERROR_SELECT) begin
               fe_flag_r <= CTRL_WDATA[`UAFC_BIT_TOP];
            end else begin
               mode_hi_r <= CTRL_WDATA[`UAFC_BIT_TOP];
            end
            mode_lo_r <= CTRL_WDATA[`UAFC_BIT_MODE_LO];
            mp_en_r   <= CTRL_WDATA[`UAFC_BIT_MP_EN];
            rx_en_r   <= CTRL_WDATA[`UAFC_BIT_RX_EN];
            tx_b8_r   <= CTRL_WDATA[`UAFC_BIT_TX_B8];
            rx_b8_r   <= CTRL_WDATA[`UAFC_BIT_RX_B8];
            tx_done_r <= CTRL_WDATA[`UAFC_BIT_TX_DONE];
            rx_done_r <= CTRL_WDATA[`UAFC_BIT_RX_DONE];
         end
         // valid later stops never clear the flag
         if (fe_event) begin
            fe_flag_r <= 1'b1;
         end
         if (tx_stop_start) begin
            tx_done_r <= 1'b1;
         end
         if (decide && accept) begin
            rx_done_r <= 1'b1;
            rx_b8_r   <= addr_bit;
         end
      end
   end

   // readback and output stage
   always @(posedge SYS_CLK) begin
      if (!RST_N) begin
         CTRL_RDATA <= `UAFC_CTRL_RESET;
         RX_VALID   <= 1'b0;
         RX_DATA    <= 9'h000;
      end else begin
         CTRL_RDATA <= {FRAME_ERROR_SELECT ? fe_flag_r : mode_hi_r,
                        mode_lo_r, mp_en_r, rx_en_r, tx_b8_r,
                        rx_b8_r, tx_done_r, rx_done_r};
         if (out_take) begin
            RX_VALID <= 1'b1;
            RX_DATA  <= fifo_out_data;
         end else if (RX_READY) begin
            RX_VALID <= 1'b0;
         end
      end
   end

   uafc_fifo #(
      .WIDTH (`UAFC_FIFO_WIDTH),
      .DEPTH (`UAFC_FIFO_DEPTH),
      .AW    (`UAFC_FIFO_AW)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .in_valid  (pend_v_r),
      .in_ready  (fifo_in_ready),
      .in_data   (pend_r),
      .out_valid (fifo_out_valid),
      .out_ready (out_take),
      .out_data  (fifo_out_data)
   );
endmodule
`default_nettype wire

// >>> core/uafc_defs.vh
// Notes on behaviour
// - transmitter and receiver run at once, each on its own bit rate.
// - stop-bit checking works in all async modes, only with error select set.
// - with checking on, a bad stop bit sets the framing error flag.
// - framing error flag clears only by software write or reset.
// - with checking on, receive done rises at the stop bit.
// - address recognition is on when multiproc enable is set in an async mode (modes 1 to 3).
// - with recognition on, receive done sets only for a matching address.
// - in mode 1 with recognition, the stop bit stands for the ninth bit.
// - mode 1 with recognition needs a match and a valid stop bit.
// - in mode 0 the multiproc enable bit does nothing.
// - an address matching the given or broadcast address is accepted.
// - given address is address byte with mask-zero bits as don't-care.
// - an all-ones mask makes only the exact address and the broadcast 8'hff match.
// - broadcast address is address OR mask, zero bits don't-care.
// - error select steers control bit 7 between mode bit and error flag.
`ifndef UAFC_DEFS_VH
`define UAFC_DEFS_VH
`define UAFC_CTRL_RESET     8'h00
`define UAFC_BIT_TOP        7
`define UAFC_BIT_MODE_LO    6
`define UAFC_BIT_MP_EN      5
`define UAFC_BIT_RX_EN      4
`define UAFC_BIT_TX_B8      3
`define UAFC_BIT_RX_B8      2
`define UAFC_BIT_TX_DONE    1
`define UAFC_BIT_RX_DONE    0
`define UAFC_MODE_SHIFT     2'h0
`define UAFC_MODE_8BIT      2'h1
`define UAFC_FIFO_WIDTH     9
`define UAFC_FIFO_DEPTH     16
`define UAFC_FIFO_AW        4
`define UAFC_DIV_W          16
`define UAFC_ST_IDLE        3'h0
`define UAFC_ST_START       3'h1
`define UAFC_ST_DATA        3'h2
`define UAFC_ST_STOP        3'h3
`define UAFC_TX_LEN_8       4'ha
`define UAFC_TX_LEN_9       4'hb
`endif

// >>> dv/uafc_serial_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module uafc_serial_monitor (
   // clock and reset
   input wire logic       SYS_CLK,
   input wire logic       RST_N,
   // control and streams
   input wire logic       TXD,
   input wire logic       FRAME_ERROR_SELECT,
   input wire logic       CTRL_WR,
   input wire logic [7:0] CTRL_WDATA,
   input wire logic [7:0] CTRL_RDATA,
   input wire logic       TX_VALID,
   input wire logic       TX_READY,
   input wire logic       RX_VALID,
   input wire logic       RX_READY,
   input wire logic [8:0] RX_DATA
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   wire m0 = CTRL_RDATA[7:6] == 2'b00 && !FRAME_ERROR_SELECT;
   reset_vals_a: assert property (disable iff (1'b0) !RST_N |=>
      TXD && !TX_READY && !RX_VALID && CTRL_RDATA == 8'h00)
      else $error("outputs not at reset level");
   ctrl_echo_a: assert property (CTRL_WR ##1 !CTRL_WR |=>
      CTRL_RDATA[6:3] == $past(CTRL_WDATA[6:3], 2))
      else $error("control write not reflected");
   mode_hi_a: assert property (CTRL_WR && !FRAME_ERROR_SELECT ##1
      !CTRL_WR && !FRAME_ERROR_SELECT |=>
      CTRL_RDATA[7] == $past(CTRL_WDATA[7], 2))
      else $error("top control bit not the mode bit");
   fe_sticky_a: assert property (FRAME_ERROR_SELECT && CTRL_RDATA[7] &&
      $past(FRAME_ERROR_SELECT) && !CTRL_WR && !$past(CTRL_WR) ##1
      FRAME_ERROR_SELECT && !CTRL_WR |=> CTRL_RDATA[7])
      else $error("framing error flag dropped");
   rx_hold_a: assert property (RX_VALID && !RX_READY |=>
      RX_VALID && $stable(RX_DATA))
      else $error("receive word not held");
   tx_start_a: assert property (TX_VALID && TX_READY |=>
      !TXD && !TX_READY ##1 !TXD)
      else $error("start bit not sent");
   tx_ready_a: assert property ($rose(TX_READY) |-> TXD && $past(TXD))
      else $error("transmitter ready inside a frame");
   mode0_a: assert property (m0 [*3] |-> !TX_READY && !$rose(RX_VALID))
      else $error("serial port active in mode 0");
   cover property (FRAME_ERROR_SELECT && CTRL_RDATA[7]);
   cover property (RX_VALID && !RX_READY);
   cover property (TX_VALID && TX_READY);
endmodule
bind uafc_serial uafc_serial_monitor uafc_serial_monitor_i (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .TXD(TXD),
   .FRAME_ERROR_SELECT(FRAME_ERROR_SELECT), .CTRL_WR(CTRL_WR),
   .CTRL_WDATA(CTRL_WDATA), .CTRL_RDATA(CTRL_RDATA), .TX_VALID(TX_VALID),
   .TX_READY(TX_READY), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
   .RX_DATA(RX_DATA));
`default_nettype wire

// >>> dv/uafc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module uafc_peer (
   // clock and bit periods
   input  wire logic        clk,
   input  wire logic [15:0] rdiv,
   input  wire logic [15:0] tdiv,
   // serial line
   output var  logic        rxd,
   input  wire logic        txd
);
   logic [7:0] tx_q[$];
   logic [7:0] cap;
   initial rxd = 1'b1;
   task automatic bit_out(input logic v);
      rxd = v;
      repeat (rdiv) @(negedge clk);
   endtask
   // one idle bit after stop so the next start is a clean edge
   task automatic send(input logic [7:0] d, input logic nine, use9, stop);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++)
         bit_out(d[i]);
      if (use9)
         bit_out(nine);
      bit_out(stop);
      bit_out(1'b1);
   endtask
   always begin
      @(negedge txd);
      repeat (tdiv / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (tdiv) @(posedge clk);
         cap = {txd, cap[7:1]};
      end
      tx_q.push_back(cap);
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, rxd, txd, rx_valid, tx_ready;
   logic        sel = 1'b0, wr = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1;
   logic [7:0]  addr = 8'h00, mask = 8'h00, wdata = 8'h00, tx_data = 8'h00;
   logic [7:0]  rdata;
   logic [8:0]  rx_data, exp_q[$], got_q[$];
   logic [15:0] rdiv = 16'h0008, tdiv = 16'h000c;
   int          n_fail = 0, n_tests = 0;
   uafc_serial uafc_serial_i (.SYS_CLK(clk), .RST_N(rst_n), .RXD(rxd),
      .TXD(txd), .RX_BIT_DIV(rdiv), .TX_BIT_DIV(tdiv),
      .FRAME_ERROR_SELECT(sel), .SLAVE_ADDR_VALUE(addr),
      .SLAVE_ADDR_MASK(mask), .CTRL_WR(wr), .CTRL_WDATA(wdata),
      .CTRL_RDATA(rdata), .TX_VALID(tx_valid), .TX_READY(tx_ready),
      .TX_DATA(tx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
      .RX_DATA(rx_data));
   uafc_peer uafc_peer_i (.clk(clk), .rdiv(rdiv), .tdiv(tdiv), .rxd(rxd),
      .txd(txd));
   always #12.5 clk = ~clk;
   always @(posedge clk)
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
         got_q.push_back(rx_data);
   task automatic chk(input string what, input logic [8:0] e, g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", what, e, g);
         n_fail++;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic matchf(input logic [7:0] r, a, m);
      return (((r ^ a) & m) == 8'h00) || ((r & (a | m)) == (a | m));
   endfunction
   task automatic wr_ctrl(input logic [7:0] v);
      wr = 1'b1;
      wdata = v;
      @(negedge clk);
      wr = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic frame(input logic [7:0] d, input logic nine, use9, stop,
                        input logic acc);
      if (acc)
         exp_q.push_back({nine, d});
      uafc_peer_i.send(d, nine, use9, stop);
   endtask
   task automatic drain;
      int k;
      k = 0;
      while (got_q.size() < exp_q.size() && k++ < 300) @(negedge clk);
      repeat (20) @(negedge clk);
      chk("rx count", 9'(exp_q.size()), 9'(got_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0)
         chk("rx word", exp_q.pop_front(), got_q.pop_front());
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic send_tx;
      int k;
      k = 0;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && k++ < 50) @(negedge clk);
      @(negedge clk);
      tx_valid = 1'b0;
      k = 0;
      while (uafc_peer_i.tx_q.size() == 0 && k++ < 400) @(negedge clk);
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      close_out;
   end
   initial begin
      logic [7:0] a, m, r;
      logic       b, acc;
      void'($urandom(32'hffd1));
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      chk("rdata", 9'h000, {1'b0, rdata});
      chk("idle", 9'h004, {6'h00, txd, tx_ready, rx_valid});
      $display("test reset done");
      wr_ctrl(8'h50);
      rx_ready = 1'b0;
      // sixteen words wait, one at the output and fifteen in the fifo, while the reader stalls
      for (int i = 0; i < 16; i++)
         frame(8'($urandom), 1'b0, 1'b0, 1'b1, 1'b1);
      chk("held", 9'h001, {8'h00, rx_valid});
      rx_ready = 1'b1;
      drain;
      chk("rx done", 9'h001, {8'h00, rdata[0]});
      $display("test stream done");
      tx_data = 8'($urandom);
      fork
         frame(8'h3c, 1'b0, 1'b0, 1'b1, 1'b1);
         send_tx;
      join
      drain;
      chk("tx count", 9'h001, 9'(uafc_peer_i.tx_q.size()));
      if (uafc_peer_i.tx_q.size() > 0)
         chk("tx byte", {1'b0, tx_data}, {1'b0, uafc_peer_i.tx_q.pop_front()});
      chk("tx done", 9'h001, {8'h00, rdata[1]});
      $display("test duplex done");
      sel = 1'b1;
      frame(8'ha5, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (20) @(negedge clk);
      got_q.delete();
      chk("fe set", 9'h001, {8'h00, rdata[7]});
      // decided at the stop sample, so bit 8 carries the stop bit
      frame(8'h5a, 1'b1, 1'b0, 1'b1, 1'b1);
      drain;
      chk("fe kept", 9'h001, {8'h00, rdata[7]});
      wr_ctrl(8'h50);
      chk("fe clear", 9'h000, {8'h00, rdata[7]});
      sel = 1'b0;
      $display("test framing done");
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 12; i++) begin
            a = 8'($urandom);
            m = 8'($urandom);
            r = 8'($urandom);
            b = (i % 4) != 3;
            case (i)
               0: begin m = 8'hff; r = a; end
               1: begin m = 8'hff; r = a ^ 8'h10; end
               2: r = 8'hff;
               4: begin a = 8'h56; m = 8'hfc; r = 8'h55; end
               5: r = a | m;
               6: r = a ^ ~m;
               default: ;
            endcase
            acc = b && matchf(r, a, m);
            addr = a;
            mask = m;
            wr_ctrl(j ? 8'h70 : (i[0] ? 8'hb0 : 8'hf0));
            frame(r, b, !j, j ? b : 1'b1, acc);
            drain;
            chk("rx done", {8'h00, acc}, {8'h00, rdata[0]});
            chk("rx ninth", {8'h00, acc}, {8'h00, rdata[2]});
         end
         $display("test address mode %0d done", j ? 1 : 3);
      end
      wr_ctrl(8'h30);
      frame(8'h81, 1'b1, 1'b1, 1'b1, 1'b0);
      drain;
      chk("mode0", 9'h000, {7'h00, rdata[0], tx_ready});
      $display("test shift mode done");
      close_out;
   end
endmodule
`default_nettype wire
